// File: src/crb_cfg.svh
// crb_cfg.svh: register offsets, field positions, reset values and timing
// figures of the channel crossbar select block.
// assumes: included by bare name from the design files of this block.
`ifndef CRB_CFG_SVH
`define CRB_CFG_SVH

// ==========================================================
// register offsets (byte addresses on the config port)
`define CRB_ADDR_FAST 8'h00
`define CRB_ADDR_SIDE 8'h01
`define CRB_ADDR_TERM 8'h10
`define CRB_ADDR_PULSE_LO 8'h11
`define CRB_ADDR_PULSE_HI 8'h12

// ==========================================================
// reset values
`define CRB_RESET_FAST 8'h40
`define CRB_RESET_SIDE 8'h40
`define CRB_RESET_TERM 8'h01
`define CRB_RESET_PULSE 8'h00

// ==========================================================
// field positions inside the route config and termination registers
`define CRB_POS_ENABLE 6
`define CRB_POS_MODE_HI 5
`define CRB_POS_MODE_LO 4
`define CRB_POS_SEL_HI 3
`define CRB_POS_SEL_LO 0
`define CRB_POS_TERM 0

// ==========================================================
// timing
`define CRB_PULSE_TIME_MS 100
`define CRB_CLOCK_HZ 125000000

`endif

// File: src/crb_pkg.sv
// crb_pkg.sv: types shared by the channel crossbar select block.
// assumes: nothing beyond a SystemVerilog compiler.
`default_nettype none

package crb_pkg;

	// ==========================================================
	// bundling modes, code 11 is never stored
	typedef enum logic [1:0] {
		crb_mode_quad = 2'b00,
		crb_mode_dual = 2'b01,
		crb_mode_single = 2'b10,
		crb_mode_illegal = 2'b11
	} crb_mode_t;

	// ==========================================================
	// one route config register as stored
	typedef struct packed {
		logic enable;
		crb_mode_t mode;
		logic [3:0] sel;
	} crb_path_cfg_t;

	// one output lane: connected flag and channel index 0..15 (a0..d3)
	typedef struct packed {
		logic enable;
		logic [3:0] chan;
	} crb_route_t;

	// the four lanes of one switch, index 0 is lane 0
	typedef crb_route_t [3:0] crb_route_set_t;

endpackage

`default_nettype wire

// File: src/crb_pulse_timer.sv
// crb_pulse_timer.sv: retriggerable one-shot that holds active for a set
// number of clock cycles after each start pulse.
// assumes: start is a one-cycle pulse from logic on the same clock.
`default_nettype none

module crb_pulse_timer #(
	parameter int unsigned CYCLES = 12500000
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic start,
	output logic active
);

	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);

	logic [CW-1:0] remain;
	logic [CW-1:0] next_remain;
	logic next_active;

	// ==========================================================
	// countdown, a new start reloads the full time
	always_comb begin
		next_remain = remain;
		if (start) begin
			next_remain = LOAD;
		end else if (remain != '0) begin
			next_remain = remain - 1'b1;
		end
		next_active = (next_remain != '0);
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			remain <= '0;
			active <= 1'b0;
		end else begin
			remain <= next_remain;
			active <= next_active;
		end
	end

endmodule // crb_pulse_timer

`default_nettype wire

// File: src/crb_channel_crossbar_select.sv
// crb_channel_crossbar_select.sv: configuration registers and routing
// decode of a four-source crossbar, fast and side switches.
// assumes: the config port is driven by a host controller on the same
// clock; analog switches consume the registered route outputs.
`default_nettype none

`include "crb_cfg.svh"

module crb_channel_crossbar_select #(
	parameter int unsigned PULSE_CYCLES =
		(`CRB_CLOCK_HZ / 1000) * `CRB_PULSE_TIME_MS
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wr_data,
	output logic [7:0] cfg_rd_data,
	output crb_pkg::crb_route_set_t fast_route,
	output logic fast_standby,
	output crb_pkg::crb_route_set_t side_route,
	output logic [15:0] term_on
);

	// ==========================================================
	// reset images and register offsets
	localparam logic [7:0] FAST_RST = `CRB_RESET_FAST;
	localparam logic [7:0] SIDE_RST = `CRB_RESET_SIDE;
	localparam logic [7:0] TERM_RST = `CRB_RESET_TERM;
	localparam logic [7:0] PULSE_RST = `CRB_RESET_PULSE;
	localparam logic [7:0] ADDR_FAST = `CRB_ADDR_FAST;
	localparam logic [7:0] ADDR_SIDE = `CRB_ADDR_SIDE;
	localparam logic [7:0] ADDR_TERM = `CRB_ADDR_TERM;
	localparam logic [7:0] ADDR_PULSE_LO = `CRB_ADDR_PULSE_LO;
	localparam logic [7:0] ADDR_PULSE_HI = `CRB_ADDR_PULSE_HI;

	// ==========================================================
	// state
	crb_pkg::crb_path_cfg_t fast_cfg;
	crb_pkg::crb_path_cfg_t next_fast_cfg;
	crb_pkg::crb_path_cfg_t side_cfg;
	crb_pkg::crb_path_cfg_t next_side_cfg;
	logic term_enable;
	logic next_term_enable;
	logic [15:0] pulse_bits;
	logic [15:0] next_pulse_bits;
	logic [7:0] next_cfg_rd_data;
	crb_pkg::crb_route_set_t next_fast_route;
	crb_pkg::crb_route_set_t next_side_route;
	logic next_fast_standby;
	logic [15:0] next_term_on;
	logic source_change;
	logic pulse_active;
	logic [15:0] pulse_mask;

	// ==========================================================
	// decode helpers

	// store a written route byte, a mode code 11 keeps the old mode
	function automatic crb_pkg::crb_path_cfg_t store_cfg(
		input crb_pkg::crb_path_cfg_t old_cfg,
		input logic [7:0] data
	);
		crb_pkg::crb_path_cfg_t cfg;
		cfg = old_cfg;
		cfg.enable = data[`CRB_POS_ENABLE];
		cfg.sel = data[`CRB_POS_SEL_HI:`CRB_POS_SEL_LO];
		if (data[`CRB_POS_MODE_HI:`CRB_POS_MODE_LO] != 2'b11) begin
			cfg.mode = crb_pkg::crb_mode_t'(data[`CRB_POS_MODE_HI:`CRB_POS_MODE_LO]);
		end
		return cfg;
	endfunction

	// read image of a route register, bit 7 reads zero
	function automatic logic [7:0] cfg_image(input crb_pkg::crb_path_cfg_t cfg);
		return {1'b0, cfg};
	endfunction

	// fast switch lanes from its config
	function automatic crb_pkg::crb_route_set_t fast_decode(
		input crb_pkg::crb_path_cfg_t cfg
	);
		crb_pkg::crb_route_set_t set;
		set = '0;
		for (int i = 0; i < 4; i++) begin
			set[i].enable = cfg.enable;
			case (cfg.mode)
				crb_pkg::crb_mode_quad: begin
					set[i].chan = {cfg.sel[1:0], 2'(i)};
				end
				crb_pkg::crb_mode_dual: begin
					set[i].chan = {cfg.sel[2:0], (i > 1)};
				end
				crb_pkg::crb_mode_single: begin
					set[i].chan = cfg.sel;
				end
				default: begin
					set[i].chan = 4'h0;
				end
			endcase
		end
		return set;
	endfunction

	// side switch lines from its config
	function automatic crb_pkg::crb_route_set_t side_decode(
		input crb_pkg::crb_path_cfg_t cfg
	);
		crb_pkg::crb_route_set_t set;
		set = '0;
		for (int i = 0; i < 4; i++) begin
			set[i].enable = cfg.enable;
			case (cfg.mode)
				crb_pkg::crb_mode_quad: begin
					set[i].chan = {cfg.sel[1:0], 2'(i)};
				end
				crb_pkg::crb_mode_dual: begin
					// lines 1:0 from a or b, lines 3:2 from c or d
					set[i].chan = {(i > 1), cfg.sel[2], cfg.sel[1:0]};
				end
				crb_pkg::crb_mode_single: begin
					set[i].chan = cfg.sel;
				end
				default: begin
					set[i].chan = 4'h0;
				end
			endcase
		end
		return set;
	endfunction

	// pulse bits to channel order: b0..b3, a0..a3, c3..c0, d3..d0
	function automatic logic [15:0] pulse_to_chan(input logic [15:0] bits);
		logic [15:0] mask;
		mask = '0;
		for (int k = 0; k < 4; k++) begin
			mask[4 + k] = bits[k];
			mask[k] = bits[4 + k];
			mask[11 - k] = bits[8 + k];
			mask[15 - k] = bits[12 + k];
		end
		return mask;
	endfunction

	// channel indices only, used to spot a change of source
	function automatic logic [15:0] chan_image(input crb_pkg::crb_route_set_t set);
		logic [15:0] img;
		img = '0;
		for (int i = 0; i < 4; i++) begin
			img[4*i +: 4] = set[i].chan;
		end
		return img;
	endfunction

	// ==========================================================
	// register writes, each path stored on its own

	always_comb begin
		next_fast_cfg = fast_cfg;
		next_side_cfg = side_cfg;
		next_term_enable = term_enable;
		next_pulse_bits = pulse_bits;
		if (cfg_wr_en) begin
			case (cfg_addr)
				ADDR_FAST: begin
					next_fast_cfg = store_cfg(fast_cfg, cfg_wr_data);
				end
				ADDR_SIDE: begin
					next_side_cfg = store_cfg(side_cfg, cfg_wr_data);
				end
				ADDR_TERM: begin
					next_term_enable = cfg_wr_data[`CRB_POS_TERM];
				end
				ADDR_PULSE_LO: begin
					next_pulse_bits[7:0] = cfg_wr_data;
				end
				ADDR_PULSE_HI: begin
					next_pulse_bits[15:8] = cfg_wr_data;
				end
				default: begin
					next_pulse_bits = pulse_bits; // unmapped writes ignored
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fast_cfg <= FAST_RST[6:0];
			side_cfg <= SIDE_RST[6:0];
			term_enable <= TERM_RST[`CRB_POS_TERM];
			pulse_bits <= {PULSE_RST, PULSE_RST};
		end else begin
			fast_cfg <= next_fast_cfg;
			side_cfg <= next_side_cfg;
			term_enable <= next_term_enable;
			pulse_bits <= next_pulse_bits;
		end
	end

	// ==========================================================
	// register reads, data one cycle after the strobe

	always_comb begin
		next_cfg_rd_data = cfg_rd_data;
		if (cfg_rd_en) begin
			case (cfg_addr)
				ADDR_FAST: begin
					next_cfg_rd_data = cfg_image(fast_cfg);
				end
				ADDR_SIDE: begin
					next_cfg_rd_data = cfg_image(side_cfg);
				end
				ADDR_TERM: begin
					next_cfg_rd_data = {7'h00, term_enable};
				end
				ADDR_PULSE_LO: begin
					next_cfg_rd_data = pulse_bits[7:0];
				end
				ADDR_PULSE_HI: begin
					next_cfg_rd_data = pulse_bits[15:8];
				end
				default: begin
					next_cfg_rd_data = 8'h00; // unmapped reads zero
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cfg_rd_data <= 8'h00;
		end else begin
			cfg_rd_data <= next_cfg_rd_data;
		end
	end

	// ==========================================================
	// routing outputs, decoded from the values being written

	always_comb begin
		next_fast_route = fast_decode(next_fast_cfg);
		next_side_route = side_decode(next_side_cfg);
		next_fast_standby = ~next_fast_cfg.enable;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fast_route <= fast_decode(FAST_RST[6:0]);
			side_route <= side_decode(SIDE_RST[6:0]);
			fast_standby <= ~FAST_RST[`CRB_POS_ENABLE];
		end else begin
			fast_route <= next_fast_route;
			side_route <= next_side_route;
			fast_standby <= next_fast_standby;
		end
	end

	// ==========================================================
	// termination pulsing on a fast source change

	// a change of any lane's channel restarts the pulse
	always_comb begin
		source_change = (chan_image(next_fast_route) != chan_image(fast_route));
		pulse_mask = pulse_to_chan(pulse_bits);
	end

	crb_pulse_timer #(
		.CYCLES(PULSE_CYCLES)
	) u_pulse_timer (
		.clock(clock),
		.rst_b(rst_b),
		.start(source_change),
		.active(pulse_active)
	);

	// termination per input channel, pulsed channels drop while active
	always_comb begin
		next_term_on = 16'h0000;
		if (term_enable) begin
			next_term_on = ~(pulse_mask & {16{pulse_active}});
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			term_on <= {16{TERM_RST[`CRB_POS_TERM]}};
		end else begin
			term_on <= next_term_on;
		end
	end

endmodule // crb_channel_crossbar_select

`default_nettype wire

// File: verification/crb_host_model.sv
// crb_host_model.sv: host controller that writes and reads the config port.
// assumes: shares the clock of the crossbar select block.
`default_nettype none

module crb_host_model (
	input wire logic clock,
	output logic cfg_wr_en,
	output logic cfg_rd_en,
	output logic [7:0] cfg_addr,
	output logic [7:0] cfg_wr_data,
	input wire logic [7:0] cfg_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// idle bus at time zero
	initial begin
		cfg_wr_en = 1'h0;
		cfg_rd_en = 1'h0;
		cfg_addr = 8'hff;
		cfg_wr_data = 8'h00;
	end

	// one write strobe, then bus scrambled so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		cfg_wr_en <= 1'h1;
		cfg_addr <= a;
		cfg_wr_data <= d;
		@(posedge clock);
		cfg_wr_en <= 1'h0;
		cfg_addr <= ~a;
		cfg_wr_data <= ~d;
	endtask

	// one read strobe, data taken after the answering edge
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(posedge clock);
		cfg_rd_en <= 1'h1;
		cfg_addr <= a;
		@(posedge clock);
		cfg_rd_en <= 1'h0;
		cfg_addr <= ~a;
		#1;
		q = cfg_rd_data;
	endtask
endmodule // crb_host_model

`default_nettype wire

// File: verification/crb_channel_crossbar_select_properties.sv
// crb_channel_crossbar_select_properties.sv: port checker of the crossbar.
// assumes: bound to crb_channel_crossbar_select, one clock domain.
`default_nettype none

module crb_checker #(
	parameter int unsigned PULSE_CYCLES = 20
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wr_data,
	input wire logic [7:0] cfg_rd_data,
	input wire crb_pkg::crb_route_set_t fast_route,
	input wire logic fast_standby,
	input wire crb_pkg::crb_route_set_t side_route,
	input wire logic [15:0] term_on
);
	// ==========================================================
	// last legal fast mode, for the refusal check
	logic fw;
	logic sw;
	logic [1:0] fmode;
	logic [1:0] next_fmode;
	assign fw = cfg_wr_en && cfg_addr == 8'h00;
	assign sw = cfg_wr_en && cfg_addr == 8'h01;
	assign next_fmode = (fw && cfg_wr_data[5:4] != 2'h3) ? cfg_wr_data[5:4] : fmode;
	// registers the held mode
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			fmode <= 2'h0;
		else
			fmode <= next_fmode;
	end

	// run of cycles with only some terminations dropped, a fast write restarts it
	logic [31:0] low_run;
	logic [31:0] next_low_run;
	always_comb begin
		next_low_run = 32'h0;
		if (!fw && term_on != 16'hffff && term_on != 16'h0000) begin
			next_low_run = low_run + 32'h1;
		end
	end

	// registers the run length
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			low_run <= 32'h0;
		end else begin
			low_run <= next_low_run;
		end
	end

	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	// ==========================================================
	// assertions
	a_standby_inverse: assert property (
		fast_standby != fast_route[0].enable) else $error("standby equals enable");
	a_fast_enable: assert property (
		fw |=> fast_route[3].enable == $past(cfg_wr_data[6])) else $error("fast enable lost");
	a_fast_quad: assert property (
		fw && cfg_wr_data[5:4] == 2'h0 |=> fast_route[1].chan == {$past(cfg_wr_data[1:0]), 2'h1})
		else $error("fast quad lane wrong");
	a_fast_dual: assert property (
		fw && cfg_wr_data[5:4] == 2'h1 |=> fast_route[2].chan == {$past(cfg_wr_data[2:0]), 1'h1})
		else $error("fast dual lane wrong");
	a_fast_single: assert property (
		fw && cfg_wr_data[5:4] == 2'h2 |=> fast_route[0].chan == $past(cfg_wr_data[3:0])
		&& fast_route[3].chan == fast_route[0].chan) else $error("fast single lane wrong");
	a_mode_kept: assert property (
		fw && cfg_wr_data[5:4] == 2'h3 && fmode == 2'h2
		|=> fast_route[1].chan == $past(cfg_wr_data[3:0])) else $error("refused mode not kept");
	a_side_dual: assert property (
		sw && cfg_wr_data[5:4] == 2'h1 |=> side_route[0].chan == {1'h0, $past(cfg_wr_data[2:0])}
		&& side_route[3].chan == {1'h1, $past(cfg_wr_data[2:0])}) else $error("side dual wrong");
	a_side_enable: assert property (
		sw |=> side_route[2].enable == $past(cfg_wr_data[6])) else $error("side enable lost");
	a_term_off: assert property (
		cfg_wr_en && cfg_addr == 8'h10 && !cfg_wr_data[0] |=> ##1 term_on == 16'h0000)
		else $error("termination not off");
	a_pulse_length: assert property (
		low_run <= PULSE_CYCLES + 32'h1) else $error("termination pulse too long");

	// main scenarios
	c_refused: cover property (fw && cfg_wr_data[5:4] == 2'h3);
	c_side_single: cover property (sw && cfg_wr_data[5:4] == 2'h2);
	c_pulse: cover property (term_on != 16'hffff && term_on != 16'h0000);
endmodule // crb_checker

bind crb_channel_crossbar_select crb_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk_u (
	.clock, .rst_b, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wr_data, .cfg_rd_data,
	.fast_route, .fast_standby, .side_route, .term_on
);

`default_nettype wire

// File: verification/test_channel_crossbar_select.sv
// test_channel_crossbar_select.sv: self-checking bench of the crossbar select.
// assumes: host model drives the config port, checker bound separately.
`default_nettype none

module test_channel_crossbar_select;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned PULSE = 20;
	logic clock = 1'h0;
	logic rst_b = 1'h0;
	logic cfg_wr_en;
	logic cfg_rd_en;
	logic fast_standby;
	logic [7:0] cfg_addr;
	logic [7:0] cfg_wr_data;
	logic [7:0] cfg_rd_data;
	logic [7:0] q;
	logic [15:0] term_on;
	crb_pkg::crb_route_set_t fast_route;
	crb_pkg::crb_route_set_t side_route;
	logic [7:0] addrs [6] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h20};
	logic [7:0] rvals [6] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00};
	int err_total = 0;
	int compares = 0;

	// ==========================================================
	// clock, host and block
	always #4 clock = ~clock;

	crb_host_model h_u (.clock, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wr_data, .cfg_rd_data);

	crb_channel_crossbar_select #(.PULSE_CYCLES(PULSE)) dut_u (
		.clock, .rst_b, .cfg_wr_en, .cfg_rd_en, .cfg_addr, .cfg_wr_data, .cfg_rd_data,
		.fast_route, .fast_standby, .side_route, .term_on
	);

	// ==========================================================
	// expected channel of one lane
	function automatic logic [3:0] lane_chan(input logic [1:0] m, input logic [3:0] s,
		input logic [1:0] l, input logic side);
		case (m)
			2'h0: return {s[1:0], l};
			2'h1: return side ? {l[1], s[2:0]} : {s[2:0], l[1]};
			default: return s;
		endcase
	endfunction

	// compare and count
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// all lanes of both switches against the config bytes
	task automatic chk_routes(input logic [7:0] f, input logic [7:0] s);
		for (int l = 0; l < 4; l++) begin
			chk("fast lane", 16'(fast_route[l]), 16'({f[6], lane_chan(f[5:4], f[3:0], 2'(l), 1'h0)}));
			chk("side lane", 16'(side_route[l]), 16'({s[6], lane_chan(s[5:4], s[3:0], 2'(l), 1'h1)}));
		end
		chk("standby", 16'(fast_standby), 16'(!f[6]));
	endtask

	// verdict
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (100000) @(posedge clock);
		err_total++;
		complete_run();
	end

	// ==========================================================
	// main sequence
	initial begin
		logic [7:0] f;
		logic [7:0] g;
		repeat (16) @(posedge clock);
		rst_b <= 1'h1;
		#1;
		chk_routes(8'h40, 8'h40);
		chk("term reset", term_on, 16'hffff);
		for (int i = 0; i < 6; i++) begin
			h_u.rd(addrs[i], q);
			chk("reset byte", 16'(q), 16'(rvals[i]));
		end
		$display("test reset done");
		for (int m = 0; m < 3; m++) begin
			for (int s = 0; s < 16; s++) begin
				f = {1'h0, 1'(s), 2'(m), 4'(s)};
				g = {1'h0, 1'(~s), 2'(2 - m), 4'(15 - s)};
				h_u.wr(8'h00, f);
				h_u.wr(8'h01, g);
				#1;
				chk_routes(f, g);
				h_u.rd(8'h00, q);
				chk("fast byte", 16'(q), 16'(f));
			end
		end
		$display("test modes done");
		h_u.wr(8'h00, 8'h65);
		h_u.wr(8'h00, 8'h79);
		h_u.wr(8'h01, 8'h14);
		h_u.wr(8'h01, 8'h3a);
		#1;
		chk_routes(8'h69, 8'h1a);
		h_u.rd(8'h00, q);
		chk("kept mode", 16'(q), 16'h0069);
		$display("test refusal done");
		h_u.wr(8'h11, 8'h10);
		h_u.wr(8'h12, 8'h81);
		h_u.rd(8'h12, q);
		chk("pulse byte", 16'(q), 16'h0081);
		repeat (PULSE + 4) @(posedge clock);
		h_u.wr(8'h00, 8'h40);
		repeat (2) @(posedge clock);
		#1;
		chk("pulse low", term_on, 16'he7fe);
		repeat (PULSE - 2) @(posedge clock);
		#1;
		chk("pulse held", term_on, 16'he7fe);
		repeat (1) @(posedge clock);
		#1;
		chk("pulse end", term_on, 16'hffff);
		h_u.wr(8'h10, 8'h00);
		repeat (2) @(posedge clock);
		#1;
		chk("term off", term_on, 16'h0000);
		h_u.wr(8'h10, 8'h01);
		repeat (2) @(posedge clock);
		#1;
		chk("term on", term_on, 16'hffff);
		$display("test termination done");
		h_u.wr(8'h00, 8'h53);
		#1;
		chk_routes(8'h53, 8'h1a);
		h_u.wr(8'h20, 8'hff);
		h_u.rd(8'h20, q);
		chk("unmapped byte", 16'(q), 16'h0000);
		h_u.rd(8'h00, q);
		chk("fast kept", 16'(q), 16'h0053);
		@(posedge clock);
		rst_b <= 1'h0;
		@(posedge clock);
		rst_b <= 1'h1;
		#1;
		chk_routes(8'h40, 8'h40);
		chk("term again", term_on, 16'hffff);
		h_u.rd(8'h00, q);
		chk("fast again", 16'(q), 16'h0040);
		$display("test reset again done");
		complete_run();
	end
endmodule // test_channel_crossbar_select

`default_nettype wire
